// ===== hdl/nip_pkg.sv
// Overview of operation
// - Eight port lines work as general-purpose inputs or outputs under software control.
// - Lower and upper nibble each take their own input or output direction.
// - Output nibbles share one global push-pull or open-drain drive setting.
// - One global software bit puts the output drivers into low-emission mode.
// - Handshake mode uses two companion control lines as strobe and acknowledge.
// - Handshake transfer direction follows the upper nibble direction setting.
package nip_pkg;
    localparam int NIP_AW = 4;
    localparam int NIP_DW = 32;
    localparam int NIP_PW = 8;

    // Register byte offsets
    localparam logic [NIP_AW-1:0] NIP_OFS_DATA = 4'h0;
    localparam logic [NIP_AW-1:0] NIP_OFS_MODE = 4'h4;
    localparam logic [NIP_AW-1:0] NIP_OFS_STAT = 4'h8;

    // Mode register fields
    localparam int NIP_MODE_DIR_LO = 0;
    localparam int NIP_MODE_DIR_HI = 1;
    localparam int NIP_MODE_OPEN_DRAIN = 2;
    localparam int NIP_MODE_LOW_EMI = 3;
    localparam int NIP_MODE_HS_EN = 4;

    // Status register fields
    localparam int NIP_STAT_TX_BUSY = 0;
    localparam int NIP_STAT_RX_FULL = 1;
    localparam int NIP_STAT_DIR_MISMATCH = 2;

    // Values after reset; direction 1 means input
    localparam logic NIP_RST_DIR = 1'b1;
    localparam logic NIP_RST_OPEN_DRAIN = 1'b0;
    localparam logic NIP_RST_LOW_EMI = 1'b0;
    localparam logic NIP_RST_HS_EN = 1'b0;
    localparam logic [7:0] NIP_RST_DATA = 8'h00;

    typedef enum logic [1:0] {
        NIP_IDLE = 2'b00,
        NIP_SETUP = 2'b01,
        NIP_DAV = 2'b10,
        NIP_REL = 2'b11
    } nip_hs_state_e;
endpackage : nip_pkg

// ===== hdl/nip_hs_if.sv
`timescale 1ns/1ns
interface nip_hs_if;
    logic en;
    logic dir_out;
    logic tx_go;
    logic tx_busy;
    logic [7:0] pins;
    logic hs_in_s;
    logic hs_out;
    logic [7:0] rx_byte;
    logic rx_full;
    logic rx_take;

    modport ctrl (output en, output dir_out, output tx_go, output pins, output hs_in_s, output rx_take,
                  input tx_busy, input hs_out, input rx_byte, input rx_full);
    modport eng (input en, input dir_out, input tx_go, input pins, input hs_in_s, input rx_take,
                 output tx_busy, output hs_out, output rx_byte, output rx_full);
endinterface : nip_hs_if

// ===== hdl/nip_hs_engine.sv
`timescale 1ns/1ns
module nip_hs_engine (
    input wire logic ref_clk,
    input wire logic rstn,
    nip_hs_if.eng hs
);
    import nip_pkg::*;

    typedef struct packed {
        nip_hs_state_e state;
        logic [7:0] rx_byte;
        logic rx_full;
        logic hs_out;
        logic hs_prev;
    } nip_eng_s;

    nip_eng_s st_r;
    nip_eng_s st_nxt;
    logic fall;

    assign fall = st_r.hs_prev && !hs.hs_in_s;

    always_comb begin
        st_nxt = st_r;
        st_nxt.hs_prev = hs.hs_in_s;
        if (!hs.en || !hs.dir_out) begin
            st_nxt.state = NIP_IDLE;
        end else begin
            unique case (st_r.state)
                NIP_IDLE: begin
                    if (hs.tx_go) begin
                        st_nxt.state = NIP_SETUP;
                    end
                end
                NIP_SETUP: begin
                    st_nxt.state = NIP_DAV;
                end
                NIP_DAV: begin
                    if (!hs.hs_in_s) begin
                        st_nxt.state = NIP_REL;
                    end
                end
                NIP_REL: begin
                    if (hs.hs_in_s) begin
                        st_nxt.state = NIP_IDLE;
                    end
                end
            endcase
        end
        // Software read clears; a strobe in the same cycle is latched only if no byte was held, else it is dropped
        if (hs.rx_take) begin
            st_nxt.rx_full = 1'b0;
        end
        if (hs.en && !hs.dir_out && fall && !st_r.rx_full) begin
            st_nxt.rx_byte = hs.pins;
            st_nxt.rx_full = 1'b1;
        end
        if (!hs.en) begin
            st_nxt.hs_out = 1'b1;
        end else if (hs.dir_out) begin
            st_nxt.hs_out = (st_nxt.state != NIP_DAV);
        end else begin
            st_nxt.hs_out = !st_nxt.rx_full;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            st_r <= '{state: NIP_IDLE, rx_byte: 8'h00, rx_full: 1'b0, hs_out: 1'b1, hs_prev: 1'b1};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign hs.tx_busy = (st_r.state != NIP_IDLE);
    assign hs.hs_out = st_r.hs_out;
    assign hs.rx_byte = st_r.rx_byte;
    assign hs.rx_full = st_r.rx_full;

    property p_dav_hold;
        @(posedge ref_clk) disable iff (!rstn)
        (hs.en && hs.dir_out && st_r.state == NIP_DAV && hs.hs_in_s) |=> !hs.hs_out;
    endproperty
    a_dav_hold: assert property (p_dav_hold) else $error("Data-available dropped before acknowledge");

    property p_ack_release;
        @(posedge ref_clk) disable iff (!rstn)
        (hs.en && hs.dir_out && st_r.state == NIP_DAV && !hs.hs_in_s) |=> (hs.hs_out && st_r.state == NIP_REL);
    endproperty
    a_ack_release: assert property (p_ack_release) else $error("Acknowledge did not end the offer");

    property p_rx_latch;
        @(posedge ref_clk) disable iff (!rstn)
        (hs.en && !hs.dir_out && fall && !st_r.rx_full)
            |=> (st_r.rx_full && !hs.hs_out && st_r.rx_byte == $past(hs.pins));
    endproperty
    a_rx_latch: assert property (p_rx_latch) else $error("Strobed byte not latched and acknowledged");

    property p_dir_follow;
        @(posedge ref_clk) disable iff (!rstn)
        (!hs.en || !hs.dir_out) |=> (st_r.state == NIP_IDLE);
    endproperty
    a_dir_follow: assert property (p_dir_follow) else $error("Output transfer active in input direction");

    c_tx_done: cover property (@(posedge ref_clk) disable iff (!rstn)
        st_r.state == NIP_REL ##[1:20] st_r.state == NIP_IDLE);
    c_rx_byte: cover property (@(posedge ref_clk) disable iff (!rstn) !st_r.rx_full ##1 st_r.rx_full);
endmodule : nip_hs_engine

// ===== hdl/nip_port.sv
`timescale 1ns/1ns
module nip_port (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [nip_pkg::NIP_AW-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [nip_pkg::NIP_DW-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [nip_pkg::NIP_DW-1:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [nip_pkg::NIP_PW-1:0] port_lines_i,
    output logic [nip_pkg::NIP_PW-1:0] port_lines_o,
    output logic [nip_pkg::NIP_PW-1:0] port_lines_oe_n,
    output logic low_emi_o,
    input wire logic handshake_line_in,
    output logic handshake_line_out
);
    import nip_pkg::*;

    typedef struct packed {
        logic [7:0] out_data;
        logic dir_lo;
        logic dir_hi;
        logic open_drain;
        logic low_emi;
        logic hs_en;
        logic [7:0] pin_s1;
        logic [7:0] pin_s2;
        logic hs_s1;
        logic hs_s2;
        logic resp;
        logic [31:0] rdata;
        logic [7:0] pin_o;
        logic [7:0] pin_oe_n;
        logic tx_go;
    } nip_top_s;

    nip_top_s st_r;
    nip_top_s st_nxt;
    nip_hs_if hs ();

    logic req;
    logic taken;
    logic tk_wr_data;
    logic tk_wr_mode;
    logic tk_rd_data;
    logic rx_mode;
    logic [7:0] pin_o_w;
    logic [7:0] pin_oe_w;
    logic [7:0] rd_port;

    assign req = avs_read || avs_write;
    assign taken = req && st_r.resp;
    assign tk_wr_data = taken && avs_write && avs_byteenable[0] && (avs_address == NIP_OFS_DATA);
    assign tk_wr_mode = taken && avs_write && avs_byteenable[0] && (avs_address == NIP_OFS_MODE);
    assign tk_rd_data = taken && avs_read && (avs_address == NIP_OFS_DATA);
    assign rx_mode = st_r.hs_en && st_r.dir_hi;

    // Per-line driver: direction per nibble, global drive style
    for (genvar i = 0; i < NIP_PW; i++) begin : g_line
        logic drive;
        logic read_val;
        assign drive = (i < NIP_PW / 2) ? !st_nxt.dir_lo : !st_nxt.dir_hi;
        assign pin_o_w[i] = st_nxt.open_drain ? 1'b0 : st_nxt.out_data[i];
        assign pin_oe_w[i] = drive ? (st_nxt.open_drain && st_nxt.out_data[i]) : 1'b1;
        assign read_val = ((i < NIP_PW / 2) ? st_r.dir_lo : st_r.dir_hi) ? st_r.pin_s2[i] : st_r.out_data[i];
        assign rd_port[i] = read_val;
    end

    always_comb begin
        st_nxt = st_r;
        st_nxt.pin_s1 = port_lines_i;
        st_nxt.pin_s2 = st_r.pin_s1;
        st_nxt.hs_s1 = handshake_line_in;
        st_nxt.hs_s2 = st_r.hs_s1;
        st_nxt.resp = req && !st_r.resp;
        st_nxt.tx_go = 1'b0;
        if (tk_wr_data && !(st_r.hs_en && !st_r.dir_hi && hs.tx_busy)) begin
            st_nxt.out_data = avs_writedata[7:0];
            st_nxt.tx_go = st_r.hs_en && !st_r.dir_hi;
        end
        if (tk_wr_mode) begin
            st_nxt.dir_lo = avs_writedata[NIP_MODE_DIR_LO];
            st_nxt.dir_hi = avs_writedata[NIP_MODE_DIR_HI];
            st_nxt.open_drain = avs_writedata[NIP_MODE_OPEN_DRAIN];
            st_nxt.low_emi = avs_writedata[NIP_MODE_LOW_EMI];
            st_nxt.hs_en = avs_writedata[NIP_MODE_HS_EN];
        end
        st_nxt.rdata = 32'h0000_0000;
        if (req && !st_r.resp && avs_read) begin
            unique case (avs_address)
                NIP_OFS_DATA: begin
                    st_nxt.rdata[7:0] = rx_mode ? hs.rx_byte : rd_port;
                end
                NIP_OFS_MODE: begin
                    st_nxt.rdata[NIP_MODE_DIR_LO] = st_r.dir_lo;
                    st_nxt.rdata[NIP_MODE_DIR_HI] = st_r.dir_hi;
                    st_nxt.rdata[NIP_MODE_OPEN_DRAIN] = st_r.open_drain;
                    st_nxt.rdata[NIP_MODE_LOW_EMI] = st_r.low_emi;
                    st_nxt.rdata[NIP_MODE_HS_EN] = st_r.hs_en;
                end
                NIP_OFS_STAT: begin
                    st_nxt.rdata[NIP_STAT_TX_BUSY] = hs.tx_busy;
                    st_nxt.rdata[NIP_STAT_RX_FULL] = hs.rx_full;
                    st_nxt.rdata[NIP_STAT_DIR_MISMATCH] = st_r.hs_en && (st_r.dir_lo != st_r.dir_hi);
                end
                default: begin
                    st_nxt.rdata = 32'h0000_0000;
                end
            endcase
        end
        st_nxt.pin_o = pin_o_w;
        st_nxt.pin_oe_n = pin_oe_w;
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            st_r <= '{out_data: NIP_RST_DATA, dir_lo: NIP_RST_DIR, dir_hi: NIP_RST_DIR,
                      open_drain: NIP_RST_OPEN_DRAIN, low_emi: NIP_RST_LOW_EMI, hs_en: NIP_RST_HS_EN,
                      pin_s1: 8'h00, pin_s2: 8'h00, hs_s1: 1'b1, hs_s2: 1'b1, resp: 1'b0,
                      rdata: 32'h0000_0000, pin_o: 8'h00, pin_oe_n: 8'hff, tx_go: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    // Handshake engine hookup; direction comes from the upper nibble
    assign hs.en = st_r.hs_en;
    assign hs.dir_out = !st_r.dir_hi;
    assign hs.tx_go = st_r.tx_go;
    assign hs.pins = st_r.pin_s2;
    assign hs.hs_in_s = st_r.hs_s2;
    assign hs.rx_take = tk_rd_data && rx_mode;

    nip_hs_engine u_eng (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .hs(hs)
    );

    assign avs_waitrequest = req && !st_r.resp;
    assign avs_readdata = st_r.rdata;
    assign port_lines_o = st_r.pin_o;
    assign port_lines_oe_n = st_r.pin_oe_n;
    assign low_emi_o = st_r.low_emi;
    assign handshake_line_out = hs.hs_out;

    property p_lo_input;
        @(posedge ref_clk) disable iff (!rstn)
        (st_r.dir_lo && !tk_wr_mode) |=> (port_lines_oe_n[3:0] == 4'hf);
    endproperty
    a_lo_input: assert property (p_lo_input) else $error("Input nibble is being driven");

    property p_push_pull;
        @(posedge ref_clk) disable iff (!rstn)
        (!st_r.dir_hi && !st_r.open_drain && !tk_wr_mode && !tk_wr_data)
            |=> (port_lines_oe_n[7:4] == 4'h0 && port_lines_o[7:4] == $past(st_r.out_data[7:4]));
    endproperty
    a_push_pull: assert property (p_push_pull) else $error("Push-pull nibble not fully driven");

    property p_open_drain;
        @(posedge ref_clk) disable iff (!rstn)
        (!st_r.dir_hi && st_r.open_drain && !tk_wr_mode && !tk_wr_data)
            |=> (port_lines_o[7:4] == 4'h0 && port_lines_oe_n[7:4] == $past(st_r.out_data[7:4]));
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("Open-drain nibble drives high");

    property p_low_emi;
        @(posedge ref_clk) disable iff (!rstn)
        tk_wr_mode |=> (low_emi_o == $past(avs_writedata[NIP_MODE_LOW_EMI]));
    endproperty
    a_low_emi: assert property (p_low_emi) else $error("Low-emission setting not applied");

    property p_write_out;
        @(posedge ref_clk) disable iff (!rstn)
        (tk_wr_data && !st_r.hs_en && !st_r.dir_lo && !st_r.dir_hi && !st_r.open_drain)
            |=> (port_lines_o == $past(avs_writedata[7:0]));
    endproperty
    a_write_out: assert property (p_write_out) else $error("Written byte not on output lines");

    property p_bus_answer;
        @(posedge ref_clk) disable iff (!rstn)
        (req && avs_waitrequest) |=> !avs_waitrequest;
    endproperty
    a_bus_answer: assert property (p_bus_answer) else $error("Bus request not answered in one wait cycle");

    c_mode_write: cover property (@(posedge ref_clk) disable iff (!rstn) tk_wr_mode);
    c_hs_send: cover property (@(posedge ref_clk) disable iff (!rstn) st_r.tx_go);
    c_read_port: cover property (@(posedge ref_clk) disable iff (!rstn) tk_rd_data && !st_r.hs_en);
endmodule : nip_port

// ===== tb/nip_periph_model.sv
`timescale 1ns/1ns
module nip_periph_model (
    input wire logic ref_clk,
    input wire logic slow,
    input wire logic [nip_pkg::NIP_PW-1:0] lines_o,
    input wire logic [nip_pkg::NIP_PW-1:0] lines_oe_n,
    input wire logic hs_dev,
    output logic [nip_pkg::NIP_PW-1:0] lines_i,
    output logic hs_per,
    output logic [7:0] rx_byte,
    output logic [7:0] rx_cnt
);
    import nip_pkg::*;
    logic [7:0] drv;
    logic drv_en;
    initial begin
        hs_per = 1'b1;
        drv_en = 1'b0;
        drv = 8'h00;
        rx_byte = 8'h00;
        rx_cnt = 8'h00;
    end
    // Board pull-ups hold every released line high while the sender is not driving
    assign lines_i = (~lines_oe_n & lines_o) | (lines_oe_n & (drv_en ? drv : 8'hff));
    // Receiver: latch on data available, answer late when slow
    always begin
        @(negedge ref_clk);
        if (hs_dev === 1'b0 && lines_oe_n[7] === 1'b0) begin
            @(posedge ref_clk);
            rx_byte <= lines_i;
            rx_cnt <= rx_cnt + 8'h01;
            repeat (slow ? 9 : 1) @(posedge ref_clk);
            hs_per <= 1'b0;
            do @(negedge ref_clk); while (hs_dev !== 1'b1);
            @(posedge ref_clk);
            hs_per <= 1'b1;
        end
    end
    // Sender: data set up before the strobe and held until acknowledged
    task automatic send(input logic [7:0] b);
        @(posedge ref_clk);
        drv <= b;
        drv_en <= 1'b1;
        @(posedge ref_clk);
        hs_per <= 1'b0;
        do @(negedge ref_clk); while (hs_dev !== 1'b0);
        @(posedge ref_clk);
        hs_per <= 1'b1;
        drv_en <= 1'b0;
    endtask : send
endmodule : nip_periph_model

// ===== tb/testbench.sv
`timescale 1ns/1ns
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin failures++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module testbench;
    import nip_pkg::*;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [NIP_AW-1:0] avs_address = 4'h0;
    logic [NIP_DW-1:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'h0;
    logic slow = 1'b0;
    logic [NIP_DW-1:0] avs_readdata, q;
    logic avs_waitrequest, low_emi_o, handshake_line_in, handshake_line_out;
    logic [NIP_PW-1:0] port_lines_i, port_lines_o, port_lines_oe_n;
    logic [7:0] rx_byte, rx_cnt;
    int failures = 0;
    int comparisons = 0;
    int cycles = 0;
    always #20 ref_clk = ~ref_clk;
    nip_port i_nip_port (.ref_clk(ref_clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .port_lines_i(port_lines_i),
        .port_lines_o(port_lines_o), .port_lines_oe_n(port_lines_oe_n), .low_emi_o(low_emi_o),
        .handshake_line_in(handshake_line_in), .handshake_line_out(handshake_line_out));
    nip_periph_model i_nip_periph_model (.ref_clk(ref_clk), .slow(slow), .lines_o(port_lines_o),
        .lines_oe_n(port_lines_oe_n), .hs_dev(handshake_line_out), .lines_i(port_lines_i),
        .hs_per(handshake_line_in), .rx_byte(rx_byte), .rx_cnt(rx_cnt));
    task print_verdict;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : print_verdict
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            print_verdict();
        end
    end
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be,
                       output logic [31:0] r);
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_write <= wr;
        avs_read <= ~wr;
        // Request held until the edge that samples waitrequest low; data taken at that edge
        do begin
            @(posedge ref_clk);
        end while (avs_waitrequest !== 1'b0);
        r = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, 4'h1, r);
    endtask : wr
    task automatic rd(input logic [3:0] a);
        bus(1'b0, a, 32'h0, 4'hf, q);
    endtask : rd
    task automatic settle;
        repeat (3) @(negedge ref_clk);
    endtask : settle
    task automatic wait_stat(input int b, input logic v);
        int n;
        n = 0;
        do begin
            rd(NIP_OFS_STAT);
            n++;
        end while (q[b] !== v && n < 100);
        `CHK("stat bit", v, q[b])
    endtask : wait_stat
    task automatic t_reset;
        rd(NIP_OFS_MODE);
        `CHK("mode", 32'h3, q)
        `CHK("oe_n", 8'hff, port_lines_oe_n)
        `CHK("hs out", 1'b1, handshake_line_out)
        rd(4'hc);
        `CHK("unmapped", 32'h0, q)
        $display("test reset done");
    endtask : t_reset
    task automatic t_gpio;
        wr(NIP_OFS_MODE, 32'h0);
        wr(NIP_OFS_DATA, 32'ha5);
        settle();
        `CHK("out", 8'ha5, port_lines_o)
        `CHK("oe_n", 8'h00, port_lines_oe_n)
        rd(NIP_OFS_DATA);
        `CHK("data", 32'ha5, q)
        wr(NIP_OFS_MODE, 32'h2);
        settle();
        `CHK("oe_n", 8'hf0, port_lines_oe_n)
        rd(NIP_OFS_DATA);
        `CHK("data", 32'hf5, q)
        wr(NIP_OFS_MODE, 32'h1);
        settle();
        `CHK("oe_n", 8'h0f, port_lines_oe_n)
        rd(NIP_OFS_DATA);
        `CHK("data", 32'haf, q)
        $display("test gpio done");
    endtask : t_gpio
    task automatic t_drive;
        wr(NIP_OFS_MODE, 32'h4);
        wr(NIP_OFS_DATA, 32'h5a);
        settle();
        `CHK("out", 8'h00, port_lines_o)
        `CHK("oe_n", 8'h5a, port_lines_oe_n)
        wr(NIP_OFS_MODE, 32'hc);
        settle();
        `CHK("low emi", 1'b1, low_emi_o)
        bus(1'b1, NIP_OFS_MODE, 32'h0, 4'h0, q);
        bus(1'b1, 4'hc, 32'h0, 4'h1, q);
        rd(NIP_OFS_MODE);
        `CHK("mode", 32'hc, q)
        wr(NIP_OFS_MODE, 32'h0);
        settle();
        `CHK("low emi", 1'b0, low_emi_o)
        `CHK("oe_n", 8'h00, port_lines_oe_n)
        $display("test drive done");
    endtask : t_drive
    task automatic t_hs_out;
        slow <= 1'b1;
        wr(NIP_OFS_MODE, 32'h10);
        wr(NIP_OFS_DATA, 32'h3c);
        wr(NIP_OFS_DATA, 32'h99);
        wait_stat(NIP_STAT_TX_BUSY, 1'b0);
        `CHK("rx", 8'h3c, rx_byte)
        `CHK("count", 8'h01, rx_cnt)
        slow <= 1'b0;
        wr(NIP_OFS_DATA, 32'hc3);
        wait_stat(NIP_STAT_TX_BUSY, 1'b0);
        `CHK("rx", 8'hc3, rx_byte)
        `CHK("count", 8'h02, rx_cnt)
        $display("test handshake out done");
    endtask : t_hs_out
    task automatic t_hs_in;
        wr(NIP_OFS_MODE, 32'h12);
        rd(NIP_OFS_STAT);
        `CHK("mismatch", 1'b1, q[NIP_STAT_DIR_MISMATCH])
        // Lower nibble given the upper nibble's direction before use
        wr(NIP_OFS_MODE, 32'h13);
        i_nip_periph_model.send(8'h81);
        wait_stat(NIP_STAT_RX_FULL, 1'b1);
        `CHK("hs out", 1'b0, handshake_line_out)
        rd(NIP_OFS_DATA);
        `CHK("rx data", 32'h81, q)
        settle();
        `CHK("hs out", 1'b1, handshake_line_out)
        rd(NIP_OFS_STAT);
        `CHK("stat", 32'h0, q)
        $display("test handshake in done");
    endtask : t_hs_in
    initial begin
        repeat (3) @(posedge ref_clk);
        rstn <= 1'b1;
        @(posedge ref_clk);
        t_reset();
        t_gpio();
        t_drive();
        t_hs_out();
        t_hs_in();
        print_verdict();
    end
endmodule : testbench
